/* ccp_pkg.sv */
package ccp_pkg;
    // Translation buffer geometry
    localparam int ROW_W = 4;
    localparam int ROWS = 16;
    localparam int SETS = 4;
    localparam int PID_W = 6;
    localparam int MCREG_W = 4;
    // Virtual address fields: set selects, row index, high page
    localparam int VA_SET_LO = 4;
    localparam int VA_ROW_LO = 14;
    localparam int VA_HIGH_LO = 18;
    localparam int HIGH_W = 14;
    localparam int OFS_W = 14;
    // Tag holder fields
    localparam int TAG_WRITABLE = 0;
    localparam int TAG_VALID = 1;
    localparam int TAG_HIGH_LO = 2;
    localparam int TAG_PID_LO = 16;
    // Data holder: real page number in the low bits
    localparam int RPAGE_W = 16;
    // Peripheral control register fields
    localparam int CTL_SETCTL = 0;
    localparam int CTL_IOREAD = 1;
    localparam int CTL_IOWRITE = 2;
    localparam int CTL_MCREG_LO = 8;
    // Coprocessor operations issued by the core
    typedef enum logic [3:0] {
        OP_TAG_FILL = 4'h0, OP_TAG_READBACK = 4'h1, OP_TAG_FETCH = 4'h2,
        OP_TAG_UPDATE = 4'h3, OP_DATA_FILL = 4'h4, OP_DATA_READBACK = 4'h5,
        OP_DATA_FETCH = 4'h6, OP_DATA_UPDATE = 4'h7, OP_CTRL_FILL = 4'h8,
        OP_LAUNCH = 4'h9, OP_GET_CTL = 4'ha, OP_USER_LOAD = 4'hb,
        OP_USER_STORE = 4'hc
    } ccp_op_t;
    // Memory controller operation kinds
    typedef enum logic [1:0] {
        MC_RD = 2'h0, MC_WR = 2'h1, MC_SET = 2'h2, MC_GET = 2'h3
    } ccp_mc_t;
    // Host register byte offsets
    localparam logic [7:0] HR_CMD = 8'h00;
    localparam logic [7:0] HR_VADDR = 8'h04;
    localparam logic [7:0] HR_WDATA = 8'h08;
    localparam logic [7:0] HR_MEMWORD = 8'h0c;
    localparam logic [7:0] HR_STATUS = 8'h10;
    localparam logic [7:0] HR_RDATA = 8'h14;
    // Host CMD and STATUS fields
    localparam int CMD_KERNEL = 8;
    localparam int CMD_PID_LO = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_PRIV = 2;
    localparam int ST_TBF = 3;
    localparam int ST_WPF = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* ccp_if.sv */
`timescale 1ns/1ps
interface ccp_if;
    import ccp_pkg::*;
    logic req;                // Core holds an operation until ack
    ccp_op_t op;              // Operation code
    logic kernel;             // Kernel mode of the issuing instruction
    logic [PID_W-1:0] pid;    // Current process id
    logic [31:0] vaddr;       // Virtual address of the instruction
    logic [31:0] wdata;       // Processor register value
    logic [31:0] mem_word;    // Word read at vaddr
    logic ack;                // One-cycle completion pulse
    logic [31:0] rdata;       // Register value or translated address back
    logic priv_fault;         // Kernel-only operation in user mode
    logic tb_fault;           // No translation found
    logic wp_fault;           // Store into read-only page
    modport dev (input req, op, kernel, pid, vaddr, wdata, mem_word,
                 output ack, rdata, priv_fault, tb_fault, wp_fault);
    modport core (output req, op, kernel, pid, vaddr, wdata, mem_word,
                  input ack, rdata, priv_fault, tb_fault, wp_fault);
endinterface

/* ccp_core_end.sv */
`timescale 1ns/1ps
// Core side: software posts an operation over AXI4-Lite and polls status
module ccp_core_end
    import ccp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    ccp_if.core cp,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // All state of this end
    typedef struct packed {
        logic awrdy, wrdy, aw_got, w_got, bvalid, arrdy, rvalid;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [1:0] bresp, rresp;
        logic [31:0] rd;
        logic req, kernel, done, priv, tbf, wpf;
        ccp_op_t op;
        logic [PID_W-1:0] pid;
        logic [31:0] vaddr, wval, mword, result;
    } ccp_core_st_t;

    ccp_core_st_t r_reg, r_next;

    // Next-state logic: bus slave plus request holder
    always_comb begin
        r_next = r_reg;
        // Address and data are taken independently, in either order
        if (s_axi_awvalid && r_reg.awrdy) begin
            r_next.awaddr = s_axi_awaddr;
            r_next.aw_got = 1'b1;
            r_next.awrdy = 1'b0;
        end
        if (s_axi_wvalid && r_reg.wrdy) begin
            r_next.wdata = s_axi_wdata;
            r_next.w_got = 1'b1;
            r_next.wrdy = 1'b0;
        end
        // Completion from the device; done is set even if cleared now
        if (cp.ack && r_reg.req) begin
            r_next.req = 1'b0;
            r_next.result = cp.rdata;
            r_next.priv = cp.priv_fault;
            r_next.tbf = cp.tb_fault;
            r_next.wpf = cp.wp_fault;
        end
        // Commit a write once both halves are in
        if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            if (r_reg.awaddr == HR_CMD) begin
                // A new command while one is pending is dropped
                if (!r_reg.req) begin
                    r_next.op = ccp_op_t'(r_reg.wdata[3:0]);
                    r_next.kernel = r_reg.wdata[CMD_KERNEL];
                    r_next.pid = r_reg.wdata[CMD_PID_LO +: PID_W];
                    r_next.req = 1'b1;
                end
            end else if (r_reg.awaddr == HR_VADDR) begin
                r_next.vaddr = r_reg.wdata;
            end else if (r_reg.awaddr == HR_WDATA) begin
                r_next.wval = r_reg.wdata;
            end else if (r_reg.awaddr == HR_MEMWORD) begin
                r_next.mword = r_reg.wdata;
            end else if (r_reg.awaddr == HR_STATUS) begin
                // Write one clears done
                if (r_reg.wdata[ST_DONE]) begin
                    r_next.done = 1'b0;
                end
            end else if (r_reg.awaddr != HR_RDATA) begin
                r_next.bresp = RESP_SLVERR;
            end
        end
        if (cp.ack && r_reg.req) begin
            r_next.done = 1'b1;
        end
        // Write response handshake reopens both channels
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.awrdy = 1'b1;
            r_next.wrdy = 1'b1;
        end
        // Read: one cycle after the address is taken
        if (s_axi_arvalid && r_reg.arrdy) begin
            r_next.arrdy = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OKAY;
            r_next.rd = 32'h0;
            if (s_axi_araddr == HR_CMD) begin
                r_next.rd = {10'h0, r_reg.pid, 7'h0, r_reg.kernel, 4'h0, r_reg.op};
            end else if (s_axi_araddr == HR_VADDR) begin
                r_next.rd = r_reg.vaddr;
            end else if (s_axi_araddr == HR_WDATA) begin
                r_next.rd = r_reg.wval;
            end else if (s_axi_araddr == HR_MEMWORD) begin
                r_next.rd = r_reg.mword;
            end else if (s_axi_araddr == HR_STATUS) begin
                r_next.rd = {27'h0, r_reg.wpf, r_reg.tbf, r_reg.priv, r_reg.done,
                             r_reg.req};
            end else if (s_axi_araddr == HR_RDATA) begin
                r_next.rd = r_reg.result;
            end else begin
                r_next.rresp = RESP_SLVERR;
            end
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
            r_next.arrdy = 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.awrdy <= 1'b1;
            r_reg.wrdy <= 1'b1;
            r_reg.arrdy <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready = r_reg.awrdy;
    assign s_axi_wready = r_reg.wrdy;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arrdy;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rresp = r_reg.rresp;
    assign s_axi_rdata = r_reg.rd;
    assign cp.req = r_reg.req;
    assign cp.op = r_reg.op;
    assign cp.kernel = r_reg.kernel;
    assign cp.pid = r_reg.pid;
    assign cp.vaddr = r_reg.vaddr;
    assign cp.wdata = r_reg.wval;
    assign cp.mem_word = r_reg.mword;
endmodule

/* ccp_dev_end.sv */
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Tag holds pid, high page, valid, writable
// - User stores need writable flag set
// - Tag fill copies register, nothing else
// - Tag readback returns tag holder
// - Tag fetch indexes row with pid
// - One-hot select bits choose sets
// - Software sets exactly one select bit
// - Tag update writes every selected set
// - Data holder carries real page number
// - Data fill and readback move data
// - Data fetch copies selected entry data
// - Data update writes every selected set
// - Control register write-only, kernel only
// - Control fill has no side effects
// - Launch kernel-only, aligned, uses memory word
// - Software sets exactly one operation bit
// - Peripheral read sends word as address
// - Peripheral write sends word as address
// - Setctl targets previously latched register
// - Getctl reads previous register, latches new
// - Getctl stalls while controller busy
// - User addresses translated, faults raised
// - Kernel-only in user mode faults
module ccp_dev_end
    import ccp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    ccp_if.dev cp,
    output logic mc_req,
    output ccp_mc_t mc_kind,
    output logic [31:0] mc_addr,
    output logic [MCREG_W-1:0] mc_reg,
    input wire logic mc_busy,
    input wire logic mc_done,
    input wire logic [31:0] mc_rdata
);
    // One-hot sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'h1, S_WAIT_FREE = 4'h2, S_WAIT_DONE = 4'h4, S_ACK = 4'h8
    } ccp_dev_s_t;

    // All state, translation buffer included
    typedef struct packed {
        ccp_dev_s_t st;
        logic ack, priv, tbf, wpf;
        logic [31:0] rdata;
        logic [31:0] tag_hold;      // xlat_tag_holding
        logic [31:0] data_hold;     // xlat_data_holding
        logic [31:0] ctl;           // periph_op_control
        logic [MCREG_W-1:0] mcreg_prev;
        logic mc_req;
        ccp_mc_t mc_kind;
        logic [31:0] mc_addr;
        logic [MCREG_W-1:0] mc_reg;
        logic [ROWS-1:0][SETS-1:0][31:0] tag_mem;
        logic [ROWS-1:0][SETS-1:0][31:0] data_mem;
    } ccp_dev_st_t;

    ccp_dev_st_t r_reg, r_next;

    // Row index: row bits of the address mixed with the process id
    function automatic logic [ROW_W-1:0] row_of(input logic [31:0] va,
                                                input logic [PID_W-1:0] pid);
        row_of = va[VA_ROW_LO +: ROW_W] ^ pid[ROW_W-1:0];
    endfunction

    // Tag match for translation of a user address
    function automatic logic tag_hit(input logic [31:0] tag, input logic [31:0] va,
                                     input logic [PID_W-1:0] pid);
        tag_hit = tag[TAG_VALID] && (tag[TAG_PID_LO +: PID_W] == pid)
                  && (tag[TAG_HIGH_LO +: HIGH_W] == va[VA_HIGH_LO +: HIGH_W]);
    endfunction

    // Kernel-only operations; only the user load and store run in user mode
    function automatic logic kern_only(input ccp_op_t op);
        kern_only = (op != OP_USER_LOAD) && (op != OP_USER_STORE);
    endfunction

    logic [ROW_W-1:0] row;
    logic [SETS-1:0] sel;
    assign row = row_of(cp.vaddr, cp.pid);
    assign sel = cp.vaddr[VA_SET_LO +: SETS];

    // Next-state logic
    always_comb begin
        logic hit;
        logic [31:0] hit_tag, hit_data;
        hit = 1'b0;
        hit_tag = 32'h0;
        hit_data = 32'h0;
        r_next = r_reg;
        r_next.ack = 1'b0;
        // Associative lookup of the user address over the four sets
        for (int i = 0; i < SETS; i++) begin
            if (!hit && tag_hit(r_reg.tag_mem[row][i], cp.vaddr, cp.pid)) begin
                hit = 1'b1;
                hit_tag = r_reg.tag_mem[row][i];
                hit_data = r_reg.data_mem[row][i];
            end
        end
        case (r_reg.st)
            S_IDLE: begin
                if (cp.req) begin
                    r_next.priv = 1'b0;
                    r_next.tbf = 1'b0;
                    r_next.wpf = 1'b0;
                    r_next.rdata = 32'h0;
                    r_next.ack = 1'b1;
                    r_next.st = S_ACK;
                    if (!cp.kernel && kern_only(cp.op)) begin
                        r_next.priv = 1'b1;
                    end else begin
                        case (cp.op)
                            OP_TAG_FILL: begin
                                r_next.tag_hold = cp.wdata;
                            end
                            OP_TAG_READBACK: begin
                                r_next.rdata = r_reg.tag_hold;
                            end
                            OP_TAG_FETCH: begin
                                // selected set tag; result undefined
                                // unless one select bit is set
                                for (int i = 0; i < SETS; i++) begin
                                    if (sel[i]) begin
                                        r_next.tag_hold = r_reg.tag_mem[row][i];
                                    end
                                end
                            end
                            OP_TAG_UPDATE: begin
                                for (int i = 0; i < SETS; i++) begin
                                    if (sel[i]) begin
                                        r_next.tag_mem[row][i] = r_reg.tag_hold;
                                    end
                                end
                            end
                            OP_DATA_FILL: begin
                                r_next.data_hold = cp.wdata;
                            end
                            OP_DATA_READBACK: begin
                                r_next.rdata = r_reg.data_hold;
                            end
                            OP_DATA_FETCH: begin
                                for (int i = 0; i < SETS; i++) begin
                                    if (sel[i]) begin
                                        r_next.data_hold = r_reg.data_mem[row][i];
                                    end
                                end
                            end
                            OP_DATA_UPDATE: begin
                                for (int i = 0; i < SETS; i++) begin
                                    if (sel[i]) begin
                                        r_next.data_mem[row][i] = r_reg.data_hold;
                                    end
                                end
                            end
                            OP_CTRL_FILL: begin
                                r_next.ctl = cp.wdata;
                            end
                            OP_LAUNCH: begin
                                // memory word is the operation address
                                r_next.mc_addr = cp.mem_word;
                                r_next.mc_reg = r_reg.mcreg_prev;
                                r_next.mcreg_prev = r_reg.ctl[CTL_MCREG_LO +: MCREG_W];
                                if (r_reg.ctl[CTL_IOREAD]) begin
                                    r_next.mc_kind = MC_RD;
                                end else if (r_reg.ctl[CTL_IOWRITE]) begin
                                    r_next.mc_kind = MC_WR;
                                end else begin
                                    r_next.mc_kind = MC_SET;
                                end
                                r_next.mc_req = 1'b1;
                                r_next.ack = 1'b0;
                                r_next.st = S_WAIT_DONE;
                            end
                            OP_GET_CTL: begin
                                r_next.ack = 1'b0;
                                r_next.st = S_WAIT_FREE;
                            end
                            OP_USER_LOAD, OP_USER_STORE: begin
                                if (cp.kernel) begin
                                    r_next.rdata = cp.vaddr;
                                end else if (!hit) begin
                                    r_next.tbf = 1'b1;
                                end else if (cp.op == OP_USER_STORE
                                             && !hit_tag[TAG_WRITABLE]) begin
                                    r_next.wpf = 1'b1;
                                end else begin
                                    r_next.rdata = {2'h0, hit_data[RPAGE_W-1:0],
                                                    cp.vaddr[OFS_W-1:0]};
                                end
                            end
                            default: begin
                                r_next.rdata = 32'h0;
                            end
                        endcase
                    end
                end
            end
            S_WAIT_FREE: begin
                // hold until the controller is free
                if (!mc_busy) begin
                    // read previous register, latch new number
                    r_next.mc_kind = MC_GET;
                    r_next.mc_reg = r_reg.mcreg_prev;
                    r_next.mcreg_prev = r_reg.ctl[CTL_MCREG_LO +: MCREG_W];
                    r_next.mc_req = 1'b1;
                    r_next.st = S_WAIT_DONE;
                end
            end
            S_WAIT_DONE: begin
                if (mc_done) begin
                    r_next.mc_req = 1'b0;
                    if (r_reg.mc_kind == MC_GET) begin
                        r_next.rdata = mc_rdata;
                    end
                    r_next.ack = 1'b1;
                    r_next.st = S_ACK;
                end
            end
            S_ACK: begin
                // Gives the core one edge to drop its request
                r_next.st = S_IDLE;
            end
            default: begin
                r_next.st = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.st <= S_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cp.ack = r_reg.ack;
    assign cp.rdata = r_reg.rdata;
    assign cp.priv_fault = r_reg.priv;
    assign cp.tb_fault = r_reg.tbf;
    assign cp.wp_fault = r_reg.wpf;
    assign mc_req = r_reg.mc_req;
    assign mc_kind = r_reg.mc_kind;
    assign mc_addr = r_reg.mc_addr;
    assign mc_reg = r_reg.mc_reg;
endmodule

/* ccp_props.sv */
`timescale 1ns/1ps
// Watches the link between the two ends
module ccp_props
    import ccp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire ccp_op_t op,
    input wire logic kernel,
    input wire logic ack,
    input wire logic [31:0] rdata,
    input wire logic priv_fault,
    input wire logic tb_fault,
    input wire logic wp_fault
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack wider than one cycle");
    a_ack_in_req: assert property (ack |-> req)
        else $error("ack without a request");
    a_local_answer: assert property (
        $rose(req) && !(kernel && op inside {OP_LAUNCH, OP_GET_CTL}) |=> ack)
        else $error("local operation not answered next cycle");
    a_long_bound: assert property ($rose(req) |-> ##[1:300] ack)
        else $error("operation never answered");
    a_user_priv: assert property (
        ack && !kernel && !(op inside {OP_USER_LOAD, OP_USER_STORE}) |-> priv_fault)
        else $error("user mode ran a kernel operation");
    a_kernel_ok: assert property (ack && kernel |-> !priv_fault)
        else $error("kernel operation refused");
    a_fault_hold: assert property (
        ack |=> $stable({priv_fault, tb_fault, wp_fault, rdata}))
        else $error("results not held after ack");
    a_kernel_flat: assert property (
        ack && kernel && op inside {OP_USER_LOAD, OP_USER_STORE} |-> !tb_fault && !wp_fault)
        else $error("kernel access faulted");
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import ccp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mc_req, mc_done;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, mc_addr, mc_rdata, st, res, lastrd, sa, t, d, va;
    logic [31:0] seed = 32'h0000005b;
    logic [3:0] s_axi_wstrb, mc_reg, sr, pr;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [5:0] pid;
    logic [2:0] lat, cb;
    logic [6:0] bcnt = 7'h0;
    logic act = 1'b0;
    ccp_mc_t mc_kind, sk;
    int mismatches = 0, check_count = 0, nmc = 0, c;
    // Controller stays busy a while after a peripheral transfer
    wire mc_busy = bcnt != 7'h0;
    ccp_if u_if();
    ccp_core_end i_ccp_core_end(.*, .cp(u_if));
    ccp_dev_end i_ccp_dev_end(.*, .cp(u_if));
    ccp_props i_ccp_props(.aclk, .aresetn, .req(u_if.req), .op(u_if.op), .kernel(u_if.kernel),
        .ack(u_if.ack), .rdata(u_if.rdata), .priv_fault(u_if.priv_fault),
        .tb_fault(u_if.tb_fault), .wp_fault(u_if.wp_fault));
    // Shift register source, so each run repeats
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Expected tag word for this process
    function automatic logic [31:0] tg(input logic [31:0] a, input logic v, input logic w);
        return {10'h0, pid, a[31:18], v, w};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, bready held until the answer
    task automatic axw(input logic [7:0] a, input logic [31:0] w);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= w;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, a > HR_RDATA ? RESP_SLVERR : RESP_OKAY);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        q = s_axi_rdata; r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One operation: post it, wait for done, fetch result, clear done
    task automatic run(input ccp_op_t o, input logic k, input logic [31:0] a, w, m);
        axw(HR_VADDR, a); axw(HR_WDATA, w); axw(HR_MEMWORD, m);
        axw(HR_CMD, {10'h0, pid, 7'h0, k, 4'h0, o});
        do axr(HR_STATUS, st, rsp); while (st[ST_DONE] !== 1'b1);
        axr(HR_RDATA, res, rsp);
        axw(HR_STATUS, 32'h2);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Controller model: random latency, records what the device asked for
    always @(posedge aclk) begin
        mc_done <= 1'b0;
        if (mc_busy) bcnt <= bcnt - 7'h1;
        if (mc_req && !act && !mc_done) begin
            act <= 1'b1; lat <= 3'(rnd()); nmc++;
            sk <= mc_kind; sa <= mc_addr; sr <= mc_reg;
            if (mc_kind == MC_GET) chk(mc_busy, 0);
        end else if (act && lat != 3'h0) lat <= lat - 3'h1;
        else if (act) begin
            act <= 1'b0; mc_done <= 1'b1; lastrd = rnd(); mc_rdata <= lastrd;
            if (sk inside {MC_RD, MC_WR}) bcnt <= 7'h50;
        end
    end
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Cut a hang short
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        summarize();
    end
    initial begin
        aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; s_axi_awaddr = 8'h0; s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; pr = 4'h0;
        pid = 6'(rnd());
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h18, t, rsp);
        chk(rsp, RESP_SLVERR);
        chk(t, 32'h0);
        axw(8'h18, 32'h0);
        for (int i = 0; i < 4; i++) begin
            t = rnd(); va = {t[31:8], 8'hf0}; t = tg(va, i != 3, i[0]); d = rnd() & 32'hffff;
            run(OP_TAG_FILL, 1, 0, t, 0); run(OP_TAG_READBACK, 1, 0, 0, 0);
            chk(res, t);
            run(OP_TAG_UPDATE, 1, va, 0, 0); run(OP_DATA_FILL, 1, 0, d, 0);
            run(OP_DATA_UPDATE, 1, va, 0, 0);
            for (int j = 0; j < 4; j++) begin
                run(OP_TAG_FILL, 1, 0, 0, 0); run(OP_DATA_FILL, 1, 0, 0, 0);
                run(OP_TAG_FETCH, 1, {va[31:8], 4'(1 << j), 4'h0}, 0, 0);
                run(OP_TAG_READBACK, 1, 0, 0, 0);
                chk(res, t);
                run(OP_DATA_FETCH, 1, {va[31:8], 4'(1 << j), 4'h0}, 0, 0);
                run(OP_DATA_READBACK, 1, 0, 0, 0);
                chk(res, d);
            end
            run(OP_USER_LOAD, 0, va, 0, 0);
            chk(st[ST_TBF], i == 3);
            if (i != 3) chk(res, {2'h0, d[15:0], va[13:0]});
            run(OP_USER_STORE, 0, va, rnd(), 0);
            if (i != 3) chk(st[ST_WPF], !i[0]);
            // Kernel mode maps flat and never faults, even on a read-only page
            run(OP_USER_STORE, 1, va, 0, 0);
            chk(res, va);
            chk(st[ST_TBF] | st[ST_WPF], 1'b0);
            $display("translation test %0d done", i);
        end
        for (int k = 0; k < 11; k++) begin
            c = nmc;
            run(ccp_op_t'(k), 0, 32'h10, rnd(), 0);
            chk(st[ST_PRIV], 1);
            chk(nmc, c);
        end
        $display("privilege test done");
        for (int n = 0; n < 5; n++) begin
            cb = n == 1 ? 3'h1 : n == 2 ? 3'h2 : n == 4 ? 3'h4 : 3'h0;
            t = rnd(); c = nmc; d = rnd() & 32'hfffffff8;
            run(OP_CTRL_FILL, 1, 0, {20'h0, t[3:0], 5'h0, cb}, 0);
            chk(nmc, c);
            run(cb == 3'h0 ? OP_GET_CTL : OP_LAUNCH, 1, d, 0, d);
            chk(sk, cb == 3'h1 ? MC_SET : cb == 3'h2 ? MC_RD : cb == 3'h4 ? MC_WR : MC_GET);
            if (cb != 3'h0) chk(sa, d);
            if (n > 0 && cb < 3'h2) chk(sr, pr);
            if (cb == 3'h0) chk(res, lastrd);
            pr = t[3:0];
            $display("controller test %0d done", n);
        end
        summarize();
    end
endmodule
